// file: src/psc_pkg.sv
// Constants and register layout shared by the supply controller files
`default_nettype none
package psc_pkg;

  // ----------------------------------------
  // Register port geometry
  // ----------------------------------------
  localparam int AW = 8;
  localparam int DW = 32;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [AW-1:0] ADDR_MONMODE = 8'h04;
  localparam logic [AW-1:0] ADDR_MODE    = 8'h08;
  localparam logic [AW-1:0] ADDR_WAKE    = 8'h0c;
  localparam logic [AW-1:0] ADDR_WAKEIN  = 8'h10;
  localparam logic [AW-1:0] ADDR_STATUS  = 8'h14;

  // ----------------------------------------
  // Password field
  // ----------------------------------------
  localparam int         KEY_HI   = 31;
  localparam int         KEY_LO   = 24;
  localparam logic [7:0] KEY_PASS = 8'ha5;

  // ----------------------------------------
  // Field positions, masks and reset values
  // ----------------------------------------
  localparam int CR_REG_STOP  = 2;
  localparam int CR_XTAL_SEL  = 3;

  localparam logic [DW-1:0] MON_MASK = 32'h0000370f;
  localparam logic [DW-1:0] MON_RST  = 32'h00000000;
  localparam int MON_TH_HI  = 3;
  localparam int MON_SP_HI  = 10;
  localparam int MON_SP_LO  = 8;
  localparam int MON_RSTEN  = 12;
  localparam int MON_IRQEN  = 13;

  localparam logic [DW-1:0] MODE_MASK = 32'h00107000;
  localparam logic [DW-1:0] MODE_RST  = 32'h00005a00;
  localparam int MODE_BOD_RST = 12;
  localparam int MODE_BOD_DIS = 13;
  localparam int MODE_REG_USE = 14;
  localparam int MODE_BYPASS  = 20;

  localparam logic [DW-1:0] WAKE_MASK = 32'h000770ee;
  localparam logic [DW-1:0] WAKE_RST  = 32'h00000000;
  localparam int WAKE_MON    = 1;
  localparam int WAKE_TIMER  = 2;
  localparam int WAKE_CAL    = 3;
  localparam int WAKE_LP0    = 5;
  localparam int WAKE_LP1    = 6;
  localparam int WAKE_LPCLR  = 7;
  localparam int WAKE_DB_HI  = 14;
  localparam int WAKE_DB_LO  = 12;
  localparam int WAKE_LPD_HI = 18;
  localparam int WAKE_LPD_LO = 16;

  localparam logic [DW-1:0] WIN_RST = 32'h00000000;
  localparam int WIN_EN_HI  = 15;
  localparam int WIN_POL_HI = 31;
  localparam int WIN_POL_LO = 16;

  // ----------------------------------------
  // Monitor sampling codes and period masks
  // ----------------------------------------
  localparam logic [2:0]  SMP_CONT = 3'h1;
  localparam logic [2:0]  SMP_32   = 3'h2;
  localparam logic [2:0]  SMP_256  = 3'h3;
  localparam logic [2:0]  SMP_2048 = 3'h4;
  localparam logic [10:0] SMK_32   = 11'h01f;
  localparam logic [10:0] SMK_256  = 11'h0ff;
  localparam logic [10:0] SMK_2048 = 11'h7ff;

  // ----------------------------------------
  // Wake debounce codes and slow period counts
  // ----------------------------------------
  localparam logic [2:0]  WDB_IMM  = 3'h0;
  localparam logic [2:0]  WDB_3    = 3'h1;
  localparam logic [2:0]  WDB_32   = 3'h2;
  localparam logic [2:0]  WDB_512  = 3'h3;
  localparam logic [2:0]  WDB_4K   = 3'h4;
  localparam logic [2:0]  WDB_32K  = 3'h5;
  localparam logic [15:0] WNEED_IMM = 16'h0001;
  localparam logic [15:0] WNEED_3   = 16'h0003;
  localparam logic [15:0] WNEED_32  = 16'h0020;
  localparam logic [15:0] WNEED_512 = 16'h0200;
  localparam logic [15:0] WNEED_4K  = 16'h1000;
  localparam logic [15:0] WNEED_32K = 16'h8000;
  localparam logic [15:0] WNEED_NONE = 16'h0000;

  // ----------------------------------------
  // Slow tick counts and the debouncer off code
  // ----------------------------------------
  localparam logic [1:0] CLR_TICKS  = 2'h2;
  localparam logic [1:0] HOLD_TICKS = 2'h2;
  localparam logic [2:0] LPD_OFF    = 3'h0;

endpackage : psc_pkg
`default_nettype wire

// file: src/psc_lpd_if.sv
// Link between the register core and the low-power debouncer
`default_nettype none
interface psc_lpd_if;
  logic [2:0] period;
  logic [1:0] enable;
  logic [1:0] polarity;
  logic [1:0] pins;
  logic       sample;
  logic [1:0] ev;

  modport ctl (output period, output enable, output polarity, output pins, output sample, input ev);
  modport dbc (input period, input enable, input polarity, input pins, input sample, output ev);
endinterface : psc_lpd_if
`default_nettype wire

// file: src/psc_lpd.sv
// Low-power debouncer for wake inputs zero and one
`default_nettype none
module psc_lpd (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic ce,
  psc_lpd_if.dbc    lpd
);
  import psc_pkg::*;

  typedef struct packed {
    logic [1:0][3:0] cnt;
    logic [1:0]      ev;
  } psc_lpd_state_t;

  psc_lpd_state_t st_reg;
  psc_lpd_state_t st_next;
  logic [3:0]     need;
  logic [3:0]     inc;

  // ----------------------------------------
  // Consecutive sample counting
  // ----------------------------------------
  always_comb begin
    st_next    = st_reg;
    st_next.ev = 2'h0;
    need       = {1'b0, lpd.period} + 4'h1;
    inc        = 4'h0;
    for (int i = 0; i < 2; i++) begin
      inc = st_reg.cnt[i] + 4'h1;
      if (!lpd.enable[i] || lpd.period == LPD_OFF) begin
        st_next.cnt[i] = 4'h0;
      end else if (lpd.sample) begin
        if (lpd.pins[i] == lpd.polarity[i]) begin
          // Saturates so one active stretch gives one event
          if (st_reg.cnt[i] != need) begin
            st_next.cnt[i] = inc;
          end
          if (inc == need) begin
            st_next.ev[i] = 1'b1;
          end
        end else begin
          st_next.cnt[i] = 4'h0;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  assign lpd.ev = st_reg.ev;

endmodule : psc_lpd
`default_nettype wire

// file: src/psc_core.sv
// Supply controller register core, reset, monitor and wake-up logic
`default_nettype none

module psc_core (
  input  wire logic                 mclk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  wire logic [psc_pkg::AW-1:0] addr,
  input  wire logic [psc_pkg::DW-1:0] wdata,
  input  wire logic                 wr,
  input  wire logic                 rd,
  output logic      [psc_pkg::DW-1:0] rdata,
  input  wire logic                 slow_tick,
  input  wire logic                 monitor_detect,
  input  wire logic                 brownout_ok,
  input  wire logic                 timer_alarm,
  input  wire logic                 calendar_alarm,
  input  wire logic [15:0]          wake_in,
  input  wire logic                 calendar_output_wave_fall,
  output logic                      core_reset_n,
  output logic                      regulator_stop,
  output logic                      slow_clock_crystal,
  output logic                      slow_oscillator_bypass,
  output logic      [3:0]           monitor_threshold,
  output logic                      monitor_sample_enable,
  output logic                      brownout_disable,
  output logic                      internal_regulator_use,
  output logic                      irq,
  output logic                      wake_up,
  output logic                      backup_clear
);
  import psc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [DW-1:0] mon;
    logic [DW-1:0] mode;
    logic [DW-1:0] wake;
    logic [DW-1:0] win;
    logic [15:0]   in_stat;
    logic          wk_stat;
    logic          monwk_stat;
    logic          bod_stat;
    logic          monrst_stat;
    logic          mon_stat;
    logic          mon_out;
    logic [1:0]    lp_stat;
    logic          xtal;
    logic          stop;
    logic          clk_xtal;
    logic [10:0]   smp_cnt;
    logic          smp_en;
    logic [15:0]   wk_cnt;
    logic [1:0]    clr_cnt;
    logic [1:0]    hold_cnt;
    logic          bod_prev;
    logic          tm_prev;
    logic          cal_prev;
    logic          rst_n_o;
    logic          irq;
    logic          wake_p;
    logic          bclr;
    logic [DW-1:0] rdata;
  } psc_state_t;

  psc_state_t    st_reg;
  psc_state_t    st_next;
  psc_lpd_if     lpd ();
  logic          key_ok;
  logic [15:0]   need;
  logic [15:0]   wk_inc;
  logic [15:0]   wk_hit;
  logic          wk_act;
  logic          wk_fire;
  logic          mon_det;
  logic          mon_rst;
  logic          bod_fall;
  logic          bod_hold;
  logic          tm_rise;
  logic          cal_rise;
  logic [1:0]    lp_ev;
  logic [DW-1:0] status;

  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [15:0] psc_wake_need(input logic [2:0] sel);
    case (sel)
      WDB_IMM: return WNEED_IMM;
      WDB_3:   return WNEED_3;
      WDB_32:  return WNEED_32;
      WDB_512: return WNEED_512;
      WDB_4K:  return WNEED_4K;
      WDB_32K: return WNEED_32K;
      default: return WNEED_NONE;
    endcase
  endfunction : psc_wake_need

  function automatic logic psc_smp_on(input logic [2:0] sel, input logic [10:0] cnt);
    case (sel)
      SMP_CONT: return 1'b1;
      SMP_32:   return (cnt & SMK_32) == 11'h000;
      SMP_256:  return (cnt & SMK_256) == 11'h000;
      SMP_2048: return (cnt & SMK_2048) == 11'h000;
      default:  return 1'b0;
    endcase
  endfunction : psc_smp_on

  // Slow countdown shared by the delayed flag clear and the reset hold
  function automatic logic [1:0] psc_tick_down(input logic tick, input logic [1:0] cnt);
    if (tick && cnt != 2'h0) begin
      return cnt - 2'h1;
    end
    return cnt;
  endfunction : psc_tick_down

  function automatic logic psc_rise(input logic now, input logic prev);
    return now & ~prev;
  endfunction : psc_rise

  // ----------------------------------------
  // Debouncer link
  // ----------------------------------------
  assign lpd.period   = st_reg.wake[WAKE_LPD_HI:WAKE_LPD_LO];
  assign lpd.enable   = {st_reg.wake[WAKE_LP1], st_reg.wake[WAKE_LP0]};
  assign lpd.polarity = st_reg.win[WIN_POL_LO+1:WIN_POL_LO];
  assign lpd.pins     = wake_in[1:0];
  assign lpd.sample   = calendar_output_wave_fall;
  assign lp_ev        = lpd.ev;

  psc_lpd u_lpd (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ce    (ce),
    .lpd   (lpd)
  );

  // ----------------------------------------
  // Event detection
  // ----------------------------------------
  assign key_ok   = wdata[KEY_HI:KEY_LO] == KEY_PASS;
  assign need     = psc_wake_need(st_reg.wake[WAKE_DB_HI:WAKE_DB_LO]);
  assign wk_inc   = st_reg.wk_cnt + 16'h0001;
  assign wk_hit   = st_reg.win[WIN_EN_HI:0] & ~(wake_in ^ st_reg.win[WIN_POL_HI:WIN_POL_LO]);
  assign wk_act   = |wk_hit;
  // The monitor is only measured once per slow period while sampling is on
  assign mon_det  = st_reg.smp_en & slow_tick & monitor_detect;
  assign mon_rst  = mon_det & st_reg.mon[MON_RSTEN];
  assign bod_fall = st_reg.bod_prev & ~brownout_ok & ~st_reg.mode[MODE_BOD_DIS];
  assign bod_hold = ~brownout_ok & ~st_reg.mode[MODE_BOD_DIS] & st_reg.mode[MODE_REG_USE]
                    & st_reg.mode[MODE_BOD_RST];
  assign tm_rise  = psc_rise(timer_alarm, st_reg.tm_prev);
  assign cal_rise = psc_rise(calendar_alarm, st_reg.cal_prev);
  assign status   = {st_reg.in_stat, 1'b0, st_reg.lp_stat, 5'h00, st_reg.clk_xtal, st_reg.mon_out,
                     st_reg.mon_stat, st_reg.monrst_stat, st_reg.bod_stat, st_reg.monwk_stat,
                     st_reg.wk_stat, 1'b0};

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_next         = st_reg;
    // Read data and pulses fall back to zero outside their single cycle
    st_next.rdata   = '0;
    st_next.wake_p  = 1'b0;
    st_next.bclr    = 1'b0;
    wk_fire         = 1'b0;
    st_next.bod_prev = brownout_ok;
    st_next.tm_prev  = timer_alarm;
    st_next.cal_prev = calendar_alarm;

    // Register writes
    if (wr) begin
      case (addr)
        ADDR_CTRL: begin
          if (key_ok) begin
            if (wdata[CR_REG_STOP]) begin
              st_next.stop = 1'b1;
            end
            if (wdata[CR_XTAL_SEL]) begin
              st_next.xtal = 1'b1;
            end
          end
        end
        ADDR_MONMODE: st_next.mon = wdata & MON_MASK;
        ADDR_MODE: begin
          if (key_ok) begin
            st_next.mode = wdata & MODE_MASK;
          end
        end
        ADDR_WAKE:   st_next.wake = wdata & WAKE_MASK;
        ADDR_WAKEIN: st_next.win  = wdata;
        default: ;
      endcase
    end

    // Delayed flag clear; the slow domain only sees the read after two ticks
    st_next.clr_cnt = psc_tick_down(slow_tick, st_reg.clr_cnt);
    if (slow_tick && st_reg.clr_cnt != 2'h0) begin
      if (st_reg.clr_cnt == 2'h1) begin
        st_next.in_stat     = 16'h0000;
        st_next.wk_stat     = 1'b0;
        st_next.monwk_stat  = 1'b0;
        st_next.bod_stat    = 1'b0;
        st_next.monrst_stat = 1'b0;
        st_next.mon_stat    = 1'b0;
        st_next.lp_stat     = 2'h0;
      end
    end

    // Register reads, answer one cycle later
    if (rd) begin
      case (addr)
        ADDR_MONMODE: st_next.rdata = st_reg.mon;
        ADDR_MODE:    st_next.rdata = st_reg.mode | (MODE_RST & ~MODE_MASK);
        ADDR_WAKE:    st_next.rdata = st_reg.wake;
        ADDR_WAKEIN:  st_next.rdata = st_reg.win;
        ADDR_STATUS: begin
          st_next.rdata   = status;
          st_next.clr_cnt = CLR_TICKS;
        end
        default:      st_next.rdata = '0;
      endcase
    end

    // Monitor sampling window
    if (slow_tick) begin
      st_next.smp_cnt = st_reg.smp_cnt + 11'h001;
    end
    st_next.smp_en = psc_smp_on(st_reg.mon[MON_SP_HI:MON_SP_LO], st_next.smp_cnt);
    if (st_reg.smp_en && slow_tick) begin
      st_next.mon_out = monitor_detect;
    end

    // Wake input debounce counter
    if (slow_tick) begin
      if (wk_act) begin
        if (st_reg.wk_cnt != need) begin
          st_next.wk_cnt = wk_inc;
        end
        if (need != WNEED_NONE && wk_inc == need) begin
          wk_fire = 1'b1;
        end
      end else begin
        st_next.wk_cnt = 16'h0000;
      end
    end

    // Sticky flags; sets come after clears so a set in the clear cycle wins
    if (mon_det) begin
      st_next.mon_stat = 1'b1;
    end
    if (mon_rst) begin
      st_next.monrst_stat = 1'b1;
    end
    if (mon_det && st_reg.wake[WAKE_MON]) begin
      st_next.monwk_stat = 1'b1;
    end
    if (bod_fall) begin
      st_next.bod_stat = 1'b1;
    end
    if (wk_fire) begin
      st_next.wk_stat = 1'b1;
      st_next.in_stat = st_next.in_stat | wk_hit;
    end
    st_next.lp_stat = st_next.lp_stat | lp_ev;

    // Core reset hold, at least one whole slow period
    // Reloads while a cause stands, so release comes two ticks after the last cause
    if (mon_rst || bod_hold) begin
      st_next.hold_cnt = HOLD_TICKS;
    end else begin
      st_next.hold_cnt = psc_tick_down(slow_tick, st_reg.hold_cnt);
    end
    st_next.rst_n_o = !(st_next.stop || st_next.hold_cnt != 2'h0);

    // Clock select, wake, interrupt and backup clear
    st_next.clk_xtal = st_next.xtal | st_next.mode[MODE_BYPASS];
    st_next.irq      = st_next.mon_stat & st_next.mon[MON_IRQEN];
    st_next.wake_p   = (mon_det & st_reg.wake[WAKE_MON])
                     | (tm_rise & st_reg.wake[WAKE_TIMER])
                     | (cal_rise & st_reg.wake[WAKE_CAL])
                     | wk_fire | (|lp_ev);
    st_next.bclr     = st_reg.wake[WAKE_LPCLR] & (|lp_ev);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      st_reg         <= '0;
      st_reg.mon     <= MON_RST;
      st_reg.mode    <= MODE_RST & MODE_MASK;
      st_reg.wake    <= WAKE_RST;
      st_reg.win     <= WIN_RST;
      st_reg.rst_n_o <= 1'b1;
      // Edge history starts at idle levels so leaving reset is no edge
      st_reg.bod_prev <= 1'b1;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata                  = st_reg.rdata;
  assign core_reset_n           = st_reg.rst_n_o;
  assign regulator_stop         = st_reg.stop;
  assign slow_clock_crystal     = st_reg.clk_xtal;
  assign slow_oscillator_bypass = st_reg.mode[MODE_BYPASS];
  assign monitor_threshold      = st_reg.mon[MON_TH_HI:0];
  assign monitor_sample_enable  = st_reg.smp_en;
  assign brownout_disable       = st_reg.mode[MODE_BOD_DIS];
  assign internal_regulator_use = st_reg.mode[MODE_REG_USE];
  assign irq                    = st_reg.irq;
  assign wake_up                = st_reg.wake_p;
  assign backup_clear           = st_reg.bclr;

endmodule : psc_core
`default_nettype wire

// file: tb/psc_core_properties.sv
// Concurrent checks on the supply controller register core ports
`default_nettype none
module psc_core_properties (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   ce,
  input wire logic [psc_pkg::AW-1:0] addr,
  input wire logic [psc_pkg::DW-1:0] wdata,
  input wire logic                   wr,
  input wire logic                   rd,
  input wire logic [psc_pkg::DW-1:0] rdata,
  input wire logic                   core_reset_n,
  input wire logic                   regulator_stop,
  input wire logic                   slow_clock_crystal,
  input wire logic                   slow_oscillator_bypass,
  input wire logic [3:0]             monitor_threshold,
  input wire logic                   brownout_disable,
  input wire logic                   internal_regulator_use
);
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  // ----------------------------------------
  // Keyed write steps
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence ctrl_key_wr;
    ce && wr && addr == ADDR_CTRL && wdata[KEY_HI:KEY_LO] == KEY_PASS;
  endsequence
  sequence ctrl_bad_wr;
    ce && wr && addr == ADDR_CTRL && wdata[KEY_HI:KEY_LO] != KEY_PASS;
  endsequence
  sequence mode_key_wr;
    ce && wr && addr == ADDR_MODE && wdata[KEY_HI:KEY_LO] == KEY_PASS;
  endsequence
  sequence mode_bad_wr;
    ce && wr && addr == ADDR_MODE && wdata[KEY_HI:KEY_LO] != KEY_PASS;
  endsequence
  sequence core_held;
    !core_reset_n && regulator_stop;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  ctrl_key_guard_a: assert property (
    ctrl_bad_wr ##0 (!regulator_stop && !slow_clock_crystal && !slow_oscillator_bypass)
    |=> !regulator_stop && !slow_clock_crystal) else $error("control write without key took effect");
  mode_key_guard_a: assert property (
    mode_bad_wr |=> $stable(brownout_disable) && $stable(internal_regulator_use) && $stable(slow_oscillator_bypass))
    else $error("mode write without key took effect");
  regulator_stop_a: assert property (ctrl_key_wr ##0 wdata[CR_REG_STOP] |=> core_held)
    else $error("regulator stop did not reset core");
  stop_sticky_a: assert property (core_held |=> core_held)
    else $error("regulator stop released");
  crystal_select_a: assert property (ctrl_key_wr ##0 wdata[CR_XTAL_SEL] |=> slow_clock_crystal)
    else $error("crystal select ignored");
  threshold_out_a: assert property (
    ce && wr && addr == ADDR_MONMODE |=> monitor_threshold == $past(wdata[MON_TH_HI:0]))
    else $error("threshold output wrong");
  mode_outputs_a: assert property (
    mode_key_wr |=> brownout_disable == $past(wdata[MODE_BOD_DIS])
    && internal_regulator_use == $past(wdata[MODE_REG_USE]) && slow_oscillator_bypass == $past(wdata[MODE_BYPASS]))
    else $error("mode outputs wrong");
  bypass_crystal_a: assert property (
    slow_oscillator_bypass && $past(slow_oscillator_bypass) |-> slow_clock_crystal)
    else $error("bypass without crystal");
  ctrl_read_zero_a: assert property (ce && rd && (addr == ADDR_CTRL || addr == 8'h18) |=> rdata == '0)
    else $error("control or unmapped read not zero");
  idle_read_zero_a: assert property (ce && !rd |=> rdata == '0)
    else $error("read data outside read slot");
  mode_reserved_a: assert property (
    ce && rd && addr == ADDR_MODE |=> (rdata & ~MODE_MASK) == 32'h00000a00)
    else $error("mode reserved bits wrong");
endmodule : psc_core_properties
bind psc_core psc_core_properties i_props (.mclk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .core_reset_n,
  .regulator_stop, .slow_clock_crystal, .slow_oscillator_bypass, .monitor_threshold, .brownout_disable,
  .internal_regulator_use);
`default_nettype wire

// file: tb/psc_core_tb.sv
// Self-checking bench for the supply controller register core
`default_nettype none
module psc_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import psc_pkg::*;
  logic mclk, rst_n, ce, wr, rd, slow_tick, mon_det, bo_ok, t_al, c_al, wf, rd_seen;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata, rdata, d;
  logic [15:0]   wake_in;
  logic [3:0]    thr;
  logic [63:0]   e;
  logic core_reset_n, reg_stop, xtal, bypass, smp_en, bo_dis, reg_use, irq, wake_up, bk_clr;
  int n_fail, num_checks, n_wake, n_clr, n_smp, w, s;
  logic [63:0] expq[$];
  logic [7:0]  ra[7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
  logic [7:0]  bo_cfg[3] = '{8'h50, 8'h40, 8'h70};
  logic [2:0]  wk_code[4] = '{3'h0, 3'h1, 3'h2, 3'h2};
  logic [31:0] lp_cfg[4] = '{32'h000100a0, 32'h000700a0, 32'h00010080, 32'h00010020};
  logic [1:0]  lp_exp[4] = '{2'b11, 2'b11, 2'b00, 2'b10};
  int smp_exp[5] = '{0, 2048, 64, 8, 1};
  int wk_need[4] = '{1, 3, 32, 32};
  int lp_n[4] = '{1, 7, 1, 1};

  psc_core i_dut (.mclk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .slow_tick, .monitor_detect(mon_det),
    .brownout_ok(bo_ok), .timer_alarm(t_al), .calendar_alarm(c_al), .wake_in, .calendar_output_wave_fall(wf),
    .core_reset_n, .regulator_stop(reg_stop), .slow_clock_crystal(xtal), .slow_oscillator_bypass(bypass),
    .monitor_threshold(thr), .monitor_sample_enable(smp_en), .brownout_disable(bo_dis),
    .internal_regulator_use(reg_use), .irq, .wake_up, .backup_clear(bk_clr));

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Drivers move 1 ns past the edge so counters updated at that edge are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    cyc(1);
    wr <= 1'b0;
    cyc(1);
  endtask : wreg

  task automatic rreg(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
    expq.push_back({m, x & m});
    addr <= a;
    rd <= 1'b1;
    cyc(1);
    rd <= 1'b0;
    cyc(1);
  endtask : rreg

  task automatic ticks(input int n);
    repeat (n) begin
      slow_tick <= 1'b1;
      cyc(1);
    end
    slow_tick <= 1'b0;
    cyc(1);
  endtask : ticks

  task automatic samples(input int n);
    repeat (n) begin
      wf <= 1'b1;
      cyc(1);
      wf <= 1'b0;
      cyc(1);
    end
  endtask : samples

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  // Outputs are watched here; read notes come off the queue one slot after each read strobe
  always @(posedge mclk) begin
    if (wake_up === 1'b1) n_wake <= n_wake + 1;
    if (bk_clr === 1'b1) n_clr <= n_clr + 1;
    if (smp_en === 1'b1 && slow_tick === 1'b1) n_smp <= n_smp + 1;
    rd_seen <= rd;
    if (rd_seen === 1'b1) begin
      e = expq.pop_front();
      check(rdata & e[63:32], e[31:0]);
    end
  end

  initial begin
    cyc(40000);
    n_fail++;
    print_verdict();
  end

  initial begin
    {rst_n, wr, rd, slow_tick, mon_det, t_al, c_al, wf} = '0;
    {ce, bo_ok} = 2'b11;
    addr = '0;
    wdata = '0;
    wake_in = '0;
    void'($urandom(32'h51ca75a5));
    cyc(8);
    rst_n <= 1'b1;
    cyc(1);
    foreach (ra[i]) rreg(ra[i], '1, (i == 2) ? 32'h00005a00 : 32'h0);
    repeat (3) begin
      d = $urandom | 32'h00100000;
      wreg(ADDR_MONMODE, d);
      check(thr, d[3:0]);
      rreg(ADDR_MONMODE, '1, d & 32'h0000370f);
      wreg(ADDR_WAKE, d);
      rreg(ADDR_WAKE, '1, d & 32'h000770ee);
      wreg(ADDR_WAKEIN, d);
      rreg(ADDR_WAKEIN, '1, d);
      wreg(ADDR_CTRL, {8'h5a, d[23:0] | 24'h00000c});
      wreg(ADDR_MODE, {8'ha5, d[23:0]});
      check({bypass, reg_use, bo_dis, xtal}, {d[20], d[14], d[13], 1'b1});
      wreg(ADDR_MODE, {8'h5a, ~d[23:0]});
      rreg(ADDR_MODE, '1, (d & 32'h00107000) | 32'h00000a00);
    end
    wreg(ADDR_MODE, 32'ha5004000);
    check({bypass, reg_use, bo_dis, xtal}, 4'b0100);
    wreg(ADDR_WAKEIN, 32'h0);
    for (int c = 0; c < 5; c++) begin
      wreg(ADDR_MONMODE, {21'h0, c[2:0], 8'h00});
      ticks(40);
      s = n_smp;
      ticks(2048);
      check(n_smp - s, smp_exp[c]);
    end
    wreg(ADDR_WAKE, 32'h2);
    wreg(ADDR_MONMODE, 32'h00003101);
    mon_det <= 1'b1;
    w = n_wake;
    ticks(3);
    check({core_reset_n, irq, n_wake > w}, 3'b011);
    mon_det <= 1'b0;
    ticks(4);
    check(core_reset_n, 1'b1);
    rreg(ADDR_STATUS, 32'h20, 32'h20);
    ticks(1);
    check(irq, 1'b1);
    ticks(1);
    check(irq, 1'b0);
    rreg(ADDR_STATUS, 32'h20, 32'h0);
    wreg(ADDR_MONMODE, 32'h1);
    wreg(ADDR_WAKE, 32'h0);
    w = n_wake;
    mon_det <= 1'b1;
    ticks(3);
    check({core_reset_n, irq, n_wake == w}, 3'b101);
    mon_det <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      wreg(ADDR_MODE, {8'ha5, 8'h00, bo_cfg[i], 8'h00});
      bo_ok <= 1'b0;
      ticks(3);
      check(core_reset_n, i != 0);
      bo_ok <= 1'b1;
      ticks(4);
    end
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_WAKE, {17'h0, wk_code[i], 12'h000});
      wreg(ADDR_WAKEIN, {16'h0001, 15'h0, i != 3});
      w = n_wake;
      wake_in <= {15'($urandom), 1'b1};
      ticks(wk_need[i] - 1);
      wake_in[0] <= 1'b0;
      ticks(2);
      wake_in[0] <= 1'b1;
      ticks(wk_need[i] + 2);
      wake_in[0] <= 1'b0;
      ticks(2);
      check(n_wake - w, i != 3);
    end
    for (int i = 0; i < 2; i++) begin
      wreg(ADDR_WAKE, (i == 0) ? 32'hc : 32'h0);
      w = n_wake;
      t_al <= 1'b1;
      cyc(3);
      t_al <= 1'b0;
      c_al <= 1'b1;
      cyc(3);
      c_al <= 1'b0;
      cyc(2);
      check(n_wake - w, (i == 0) ? 2 : 0);
    end
    wreg(ADDR_WAKEIN, 32'h00010000);
    for (int i = 0; i < 4; i++) begin
      wreg(ADDR_WAKE, lp_cfg[i]);
      wake_in[0] <= 1'b1;
      w = n_wake;
      s = n_clr;
      samples(lp_n[i]);
      cyc(3);
      check(n_wake - w, 0);
      samples(1);
      cyc(3);
      check(n_wake - w, lp_exp[i][1]);
      check(n_clr - s, lp_exp[i][0]);
      wake_in[0] <= 1'b0;
      samples(2);
    end
    ce <= 1'b0;
    wreg(ADDR_MONMODE, 32'h0000000f);
    ce <= 1'b1;
    check(thr, 4'h1);
    wreg(ADDR_CTRL, 32'h5a00000c);
    check({reg_stop, xtal}, 2'b00);
    wreg(ADDR_CTRL, 32'ha5000008);
    check({reg_stop, xtal, core_reset_n}, 3'b011);
    wreg(ADDR_CTRL, 32'ha5000004);
    check({reg_stop, core_reset_n}, 2'b10);
    rreg(ADDR_CTRL, '1, 32'h0);
    print_verdict();
  end
endmodule : psc_core_tb
`default_nettype wire
